// ---- ttu_tap_tempo.sv ----
// Tap tempo unit: debounces a tap button and measures sample periods between two taps.
// Assumes tap_pin_i is already synchronous to mclk_i and is high while pressed.
`timescale 1ns/1ps
`default_nettype none
module ttu_tap_tempo
   import ttu_pkg::*;
#(
   parameter int unsigned SAMPLE_DIV_P = ttu_pkg::SAMPLE_DIV   // Core clocks per sample
)(
   // Clock and reset
   input  wire  logic                      mclk_i,
   input  wire  logic                      resetn_i,
   // Button pin
   input  wire  logic                      tap_pin_i,
   // Load-time settings, held steady while running
   input  wire  logic [ttu_pkg::CFG_W-1:0] hold_threshold_i,
   input  wire  logic [ttu_pkg::CFG_W-1:0] debounce_reload_i,
   // Timeout limit register access
   input  wire  logic                      timeout_wr_i,
   input  wire  logic [ttu_pkg::REG_W-1:0] timeout_wdata_i,
   output logic       [ttu_pkg::REG_W-1:0] tap_timeout_limit_o,
   // Measured interval and status
   output logic       [ttu_pkg::REG_W-1:0] tap_interval_o,
   output ttu_pkg::ttu_status_t            status_o,
   output logic                            sample_tick_o
);
   import ttu_pkg::*;

   // Divider too short to give a single-cycle strobe is refused
   if (SAMPLE_DIV_P < 2 || SAMPLE_DIV_P > 65536)
   begin : g_bad_div
      $error("SAMPLE_DIV_P must lie between 2 and 65536");
   end

   localparam logic [15:0] DIV_LAST = 16'(SAMPLE_DIV_P - 1);

   // Saturating increment, shared by the hold and interval counters
   function automatic logic [32:0] sat_inc(input logic [32:0] v, input logic [32:0] lim);
      sat_inc = (v >= lim) ? lim : v + 33'h0_0000_0001;
   endfunction

   logic [15:0]  div_q, div_d;             // Sample period divider
   logic         tick_q, tick_d;           // One-cycle sample strobe
   logic [15:0]  db_cnt_q, db_cnt_d;       // Debounce disagreement counter
   logic         db_q, db_d;               // Debounced level
   ttu_state_t   st_q, st_d;               // Tap sequence state
   logic [31:0]  ivl_cnt_q, ivl_cnt_d;     // Samples since first press
   logic [31:0]  ivl_q, ivl_d;             // Measured interval register
   logic [31:0]  tmo_q, tmo_d;             // Timeout limit register
   logic [16:0]  hold_cnt_q, hold_cnt_d;   // Samples the press has lasted
   logic         long_q, long_d;           // First press went past threshold
   ttu_status_t  stat_q, stat_d;           // Registered status flags
   logic         press_now, release_now;   // Debounced edges this strobe
   logic [32:0]  tmp;                      // Scratch for saturating counts

   // Sample strobe divider
   always_comb
   begin
      tick_d = (div_q == DIV_LAST);
      div_d  = tick_d ? 16'h0000 : div_q + 16'h0001;
   end

   always_ff @(posedge mclk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         div_q  <= 16'h0000;
         tick_q <= 1'b0;
      end
      else
      begin
         div_q  <= div_d;
         tick_q <= tick_d;
      end
   end

   // Debounce: the raw pin must disagree for the reload count of samples before the level flips
   always_comb
   begin
      db_d     = db_q;
      db_cnt_d = db_cnt_q;
      if (tick_q)
      begin
         if (tap_pin_i == db_q)
            db_cnt_d = 16'h0000;                                        // Bounce restarts the wait
         else if (db_cnt_q + 16'h0001 >= debounce_reload_i)
         begin
            db_d     = tap_pin_i;
            db_cnt_d = 16'h0000;
         end
         else
            db_cnt_d = db_cnt_q + 16'h0001;
      end
      press_now   = tick_q && db_d && !db_q;
      release_now = tick_q && !db_d && db_q;
   end

   always_ff @(posedge mclk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         db_q     <= 1'b0;
         db_cnt_q <= 16'h0000;
      end
      else
      begin
         db_q     <= db_d;
         db_cnt_q <= db_cnt_d;
      end
   end

   // Tap sequence, counters and flags
   always_comb
   begin
      st_d       = st_q;
      ivl_cnt_d  = ivl_cnt_q;
      ivl_d      = ivl_q;
      long_d     = long_q;
      hold_cnt_d = hold_cnt_q;
      tmp        = 33'h0_0000_0000;
      // Program write to the timeout limit
      tmo_d      = timeout_wr_i ? timeout_wdata_i : tmo_q;
      stat_d     = stat_q;
      if (tick_q)
      begin
         // Event flags live for one sample period
         stat_d.new_interval_flag  = 1'b0;
         stat_d.press_event_flag   = press_now;
         stat_d.release_event_flag = release_now;
         stat_d.debounced_level_bit = db_d;
         // Hold length counts while pressed and saturates above the threshold
         if (press_now || !db_d)
            hold_cnt_d = 17'h0_0000;
         else
         begin
            tmp        = sat_inc({16'h0000, hold_cnt_q}, {17'h0_0000, hold_threshold_i} + 33'h1);
            hold_cnt_d = tmp[16:0];
         end
         stat_d.held_flag = db_d && !press_now && (hold_cnt_d > {1'b0, hold_threshold_i});
         tmp       = sat_inc({1'b0, ivl_cnt_q}, {1'b0, 32'hffff_ffff});
         ivl_cnt_d = tmp[31:0];
         case (st_q)
            TTU_IDLE:
            begin
               if (press_now)
               begin
                  st_d      = TTU_FIRST;
                  ivl_cnt_d = 32'h0000_0000;
                  long_d    = 1'b0;
               end
            end
            TTU_FIRST:
            begin
               if (stat_d.held_flag)
                  long_d = 1'b1;
               if (release_now && long_q)
                  st_d = TTU_IDLE;
               else if (press_now)
               begin
                  st_d  = TTU_SECOND;
                  ivl_d = ivl_cnt_q + 32'h0000_0001;
                  stat_d.new_interval_flag = 1'b1;
               end
               else if (!long_q && !db_d && ivl_cnt_q >= tmo_q)
                  st_d = TTU_IDLE;
            end
            TTU_SECOND:
            begin
               // A held second tap keeps its reading; the held flag runs on its own
               if (release_now)
                  st_d = TTU_IDLE;
            end
            default:
               st_d = TTU_IDLE;
         endcase
         stat_d.tap_phase_bit = (st_d == TTU_SECOND);
      end
   end

   always_ff @(posedge mclk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         st_q       <= TTU_IDLE;
         ivl_cnt_q  <= 32'h0000_0000;
         ivl_q      <= INTERVAL_RST;
         tmo_q      <= TIMEOUT_RST;
         hold_cnt_q <= 17'h0_0000;
         long_q     <= 1'b0;
         stat_q     <= '0;
      end
      else
      begin
         st_q       <= st_d;
         ivl_cnt_q  <= ivl_cnt_d;
         ivl_q      <= ivl_d;
         tmo_q      <= tmo_d;
         hold_cnt_q <= hold_cnt_d;
         long_q     <= long_d;
         stat_q     <= stat_d;
      end
   end

   // Outputs, all from flops; settings are inputs only, never readable here
   assign tap_timeout_limit_o = tmo_q;
   assign tap_interval_o      = ivl_q;
   assign status_o            = stat_q;
   assign sample_tick_o       = tick_q;

   // Checks
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!resetn_i);

   sequence s_second_press;
      st_q == TTU_FIRST && tick_q && !db_q ##1 db_q;
   endsequence

   tick_one_a:   assert property (tick_q |=> !tick_q)
      else $error("sample strobe longer than one cycle");
   db_strobe_a:  assert property ($changed(db_q) |-> $past(tick_q))
      else $error("debounced level moved off the strobe");
   new_pulse_a:  assert property ($changed(stat_q.new_interval_flag) |-> $past(tick_q))
      else $error("new interval flag not one sample long");
   new_load_a:   assert property (s_second_press |-> stat_q.new_interval_flag && ivl_q == $past(ivl_cnt_q) + 32'h1)
      else $error("second press did not load interval");
   phase_state_a: assert property (stat_q.tap_phase_bit |-> st_q == TTU_SECOND)
      else $error("phase bit set outside second tap");
   held_level_a: assert property (stat_q.held_flag |-> db_q)
      else $error("held flag without press");
   press_flag_a: assert property ($rose(stat_q.press_event_flag) |-> db_q)
      else $error("press event without pressed level");
   rel_flag_a:   assert property ($rose(stat_q.release_event_flag) |-> !db_q)
      else $error("release event while pressed");
   timeout_a:    assert property (st_q == TTU_FIRST && tick_q && !long_q && !db_q && !db_d
                                  && ivl_cnt_q >= tmo_q |=> st_q == TTU_IDLE)
      else $error("timeout did not restart sequence");
   // A sticky new-interval flag would hide a missed second update from the program
   new_once_a:   assert property (stat_q.new_interval_flag && tick_q |=> !stat_q.new_interval_flag)
      else $error("new interval flag outlived its sample");
   // Saturation must keep the hold count above the threshold for a long press
   held_keep_a:  assert property (stat_q.held_flag && tick_q && db_d |=> stat_q.held_flag)
      else $error("held flag dropped while still pressed");
   long_rel_a:   assert property (st_q == TTU_FIRST && long_q && release_now |=> st_q == TTU_IDLE)
      else $error("long first press did not restart sequence");
endmodule
`default_nettype wire

// ---- ttu_pkg.sv ----
// Shared constants and types for the tap tempo unit.
// Assumes a single 125 MHz core clock and a fixed audio sample rate.
`default_nettype none
package ttu_pkg;
   // Core clock and audio sample rate
   localparam int unsigned CLK_HZ         = 125_000_000;
   localparam int unsigned SAMPLE_RATE_HZ = 48_000;
   // Core clocks per sample period, rounded down
   localparam int unsigned SAMPLE_DIV     = CLK_HZ / SAMPLE_RATE_HZ;
   // Special function register addresses of the two visible registers
   localparam logic [5:0]  TIMEOUT_ADDR   = 6'h2c;
   localparam logic [5:0]  INTERVAL_ADDR  = 6'h2d;
   // Register widths
   localparam int unsigned CFG_W          = 16;
   localparam int unsigned REG_W          = 32;
   // Values after reset
   localparam logic [31:0] TIMEOUT_RST    = 32'h0000_ffff;
   localparam logic [31:0] INTERVAL_RST   = 32'h0000_0000;

   // Tap sequence states, one-hot
   typedef enum logic [2:0] {
      TTU_IDLE   = 3'b001,   // Awaiting a first tap
      TTU_FIRST  = 3'b010,   // First tap seen, measuring
      TTU_SECOND = 3'b100    // Second tap pressed, until release
   } ttu_state_t;

   // Status flags seen by the program
   typedef struct packed {
      logic new_interval_flag;
      logic tap_phase_bit;
      logic press_event_flag;
      logic release_event_flag;
      logic debounced_level_bit;
      logic held_flag;
   } ttu_status_t;
endpackage
`default_nettype wire

// ---- ttu_button_model.sv ----
// Behavioural tap button standing on the far side of the tap pin.
// Assumes the unit's sample strobe is visible and that the pin has a pull-down.
`timescale 1ns/1ps
`default_nettype none
module ttu_button_model (
   // Core clock and sample strobe
   input  wire logic mclk_i,
   input  wire logic sample_tick_i,
   // Button pin, high while pressed
   output var  logic tap_pin_o
);
   // Released button reads low through the pull-down
   initial tap_pin_o = 1'b0;

   // Drive a level for n sample strobes; the pin only moves on a strobe cycle,
   // so each level is seen by exactly n strobes and never by a partial one
   task automatic hold(input logic lvl, input int n);
      tap_pin_o = lvl;
      repeat (n)
      begin
         do @(negedge mclk_i); while (sample_tick_i !== 1'b1);
      end
   endtask
endmodule
`default_nettype wire

// ---- ttu_tap_tempo_tb.sv ----
// Self-checking bench for the tap tempo unit, sample strobe shortened to 4 clocks.
// Assumes the button model above and the unit's package.
`timescale 1ns/1ps
`default_nettype none
module ttu_tap_tempo_tb;
   import ttu_pkg::*;
   // One tap set: presses, gap, expected interval, new-flag cycles, held, phase
   typedef struct packed
   {
      logic [7:0] p1, g1, p2; logic [31:0] ivl; logic [7:0] nc; logic hs, ph;
   } ttu_row_t;
   logic        mclk_i   = 1'b0;   // Core clock
   logic        resetn_i = 1'b0;   // Reset, active low
   logic        wr       = 1'b0;   // Timeout write strobe
   logic [31:0] wdata    = 32'h0;  // Timeout write data
   wire  logic  pin;               // Button pin
   logic [31:0] lim, ivl;          // Register outputs
   ttu_status_t st;                // Status flags
   logic        tick;              // Sample strobe
   int n_fail = 0, n_tests = 0;
   integer c_new, c_held, c_ph, c_pe, c_re, c_db;  // Cycles each flag stood high; four-state so an unknown shows
   // Normal, held second tap, held first tap, late second tap
   ttu_row_t rows [4] = '{'{8'h3, 8'ha, 8'h3, 32'hd, 8'h4, 1'b0, 1'b1},
                          '{8'h3, 8'h7, 8'hc, 32'ha, 8'h4, 1'b1, 1'b1},
                          '{8'hc, 8'h5, 8'h3, 32'ha, 8'h0, 1'b1, 1'b0},
                          '{8'h3, 8'h1e, 8'h3, 32'ha, 8'h0, 1'b0, 1'b0}};

   ttu_tap_tempo #(.SAMPLE_DIV_P(4)) ttu_tap_tempo_i (
      .mclk_i(mclk_i), .resetn_i(resetn_i), .tap_pin_i(pin),
      .hold_threshold_i(16'h0006), .debounce_reload_i(16'h0002),
      .timeout_wr_i(wr), .timeout_wdata_i(wdata), .tap_timeout_limit_o(lim),
      .tap_interval_o(ivl), .status_o(st), .sample_tick_o(tick));
   ttu_button_model ttu_button_model_i (.mclk_i(mclk_i), .sample_tick_i(tick), .tap_pin_o(pin));

   always #4 mclk_i = ~mclk_i;

   // Flags are tallied on the falling edge, clear of the registers' update
   always @(negedge mclk_i)
   begin
      c_new  += st.new_interval_flag;
      c_held += st.held_flag;
      c_ph   += st.tap_phase_bit;
      c_pe   += st.press_event_flag;
      c_re   += st.release_event_flag;
      c_db   += st.debounced_level_bit;
   end

   // Compare and count
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("BAD %s expected %0h seen %0h", nm, exp, seen);
      end
   endtask

   task automatic finish_test;
      $display("Checks %0d, mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask

   // One timeout write slot per clock, driven off the sampling edge
   task automatic put(input logic [31:0] v, input logic we);
      @(negedge mclk_i);
      wr = we;
      wdata = v;
   endtask

   task automatic clr;
      c_new  = 0;
      c_held = 0;
      c_ph   = 0;
      c_pe   = 0;
      c_re   = 0;
      c_db   = 0;
   endtask

   // Values the register and status outputs must show while reset is held
   task automatic chk_rst;
      check("limit rst", lim, TIMEOUT_RST);
      check("interval rst", ivl, INTERVAL_RST);
      check("status rst", 32'(st), 32'h0);
   endtask

   // Watchdog: the whole run needs well under 3000 clocks
   initial
   begin
      #160000;
      n_fail++;
      finish_test();
   end

   initial
   begin
      clr();
      repeat (5) @(negedge mclk_i);
      chk_rst();
      resetn_i = 1'b1;
      // Back-to-back writes, each visible one cycle later
      put(32'h7, 1'b1);
      put(32'h14, 1'b1);
      check("limit", lim, 32'h7);
      put(32'h0, 1'b0);
      check("limit", lim, 32'h14);
      ttu_button_model_i.hold(1'b0, 4);
      foreach (rows[k])
      begin
         clr();
         ttu_button_model_i.hold(1'b1, rows[k].p1);
         ttu_button_model_i.hold(1'b0, rows[k].g1);
         ttu_button_model_i.hold(1'b1, rows[k].p2);
         ttu_button_model_i.hold(1'b0, 40);
         check("interval", ivl, rows[k].ivl);
         check("new cycles", 32'(c_new), 32'(rows[k].nc));
         check("held seen", 32'(c_held != 0), 32'(rows[k].hs));
         check("phase seen", 32'(c_ph != 0), 32'(rows[k].ph));
         check("press cycles", 32'(c_pe), 32'h8);
         check("release cycles", 32'(c_re), 32'h8);
         check("level cycles", 32'(c_db), 32'((rows[k].p1 + rows[k].p2) * 4));
         check("idle status", 32'(st), 32'h0);
      end
      // A one-sample glitch is shorter than the debounce time
      clr();
      ttu_button_model_i.hold(1'b1, 1);
      ttu_button_model_i.hold(1'b0, 10);
      check("glitch", 32'(c_pe + c_db), 32'h0);
      // Strobe is one clock wide and repeats every 4 clocks
      @(negedge mclk_i);
      check("tick low", 32'(tick), 32'h0);
      repeat (3) @(negedge mclk_i);
      check("tick high", 32'(tick), 32'h1);
      // Second reset in mid-run restores every register
      resetn_i = 1'b0;
      repeat (2) @(negedge mclk_i);
      chk_rst();
      resetn_i = 1'b1;
      // After release the divider restarts: no strobe until the fourth edge
      repeat (3) @(negedge mclk_i);
      check("tick after rst", 32'(tick), 32'h0);
      check("limit after rst", lim, TIMEOUT_RST);
      @(negedge mclk_i);
      check("first tick", 32'(tick), 32'h1);
      finish_test();
   end
endmodule
`default_nettype wire
